// *** src/fsfb_top.sv ***
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "fsfb_defs.svh"

// Notes on behaviour
// - Consistency failure sets fault bit 5
// - Bit 4 drives fault output, default 0
// - Power-on reset sets bit 3 until cleared
// - Power-on loads defaults, copies protected group
// - Received check-code mismatch sets bit 2
// - Any cell undervoltage sets bit 1
// - Cell overvoltage sets bit 0
// - Overvoltage cell bits 5-0, cell 1 low
// - Undervoltage cell bits 5-0, cell 1 low
// - Parity results, first eight registers, 0x24
// - Parity results, next eight registers, 0x25
// - Write 1 clears flags; bit 4 plain
module fsfb_top (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Fault sources
    input wire logic consistency_err,
    input wire logic crc_err,
    input wire logic [`FSFB_NCELL-1:0] high_cell_bits,
    input wire logic [`FSFB_NCELL-1:0] low_cell_bits,
    // Protected configuration group
    input wire logic [`FSFB_NPROT*8-1:0] protected_config_group,
    input wire logic parity_odd_sense,
    // Outputs
    output logic fault_out,
    output logic cfg_load,
    output logic irq
);
    fsfb_pkg::fsfb_idx_t idx;
    fsfb_pkg::fsfb_flags_t flag_q;
    fsfb_pkg::fsfb_flags_t flag_set;
    fsfb_pkg::fsfb_flags_t flag_clr;
    fsfb_pkg::fsfb_flags_t irq_stat_q;
    fsfb_pkg::fsfb_flags_t irq_clr;
    fsfb_pkg::fsfb_flags_t irq_en_q;
    logic [`FSFB_NCELL-1:0] ov_cell_q;
    logic [`FSFB_NCELL-1:0] uv_cell_q;
    logic [`FSFB_NCELL-1:0] ov_clr;
    logic [`FSFB_NCELL-1:0] uv_clr;
    logic [`FSFB_NPROT-1:0] par_q;
    logic force_q;
    logic por_pend_q;
    logic wr_go;
    logic rd_go;
    logic lane0;
    fsfb_pkg::fsfb_byte_t wbyte;
    fsfb_pkg::fsfb_byte_t rd_d;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    assign idx = avs_address[7:2];
    assign lane0 = avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];
    assign wr_go = avs_write && !avs_waitrequest && lane0;
    assign rd_go = avs_read && avs_waitrequest;

    // One wait cycle, then the request completes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // ----------------------------------------
    // Fault source flags
    // ----------------------------------------
    always_comb begin
        flag_set = `FSFB_ZERO6;
        flag_set[`FSFB_B_CONS] = consistency_err;
        flag_set[`FSFB_B_CRC] = crc_err;
        flag_set[`FSFB_B_CUV] = |low_cell_bits;
        flag_set[`FSFB_B_COV] = |high_cell_bits;
        flag_clr = `FSFB_ZERO6;
        if (wr_go && idx == `FSFB_IDX_FAULT) begin
            flag_clr = wbyte[`FSFB_NFLAG-1:0];
            flag_clr[`FSFB_B_FORCE] = 1'b0;
        end
    end

    // Power-on value has the reset flag already set
    fsfb_sticky_bits #(.W(`FSFB_NFLAG), .RST(`FSFB_FLAG_RST)) u_flags (
        .clk(clk),
        .resetn(resetn),
        .set(flag_set),
        .clr(flag_clr),
        .q(flag_q)
    );

    // Self-test bit keeps what is written
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            force_q <= `FSFB_FORCE_RST;
        end else if (wr_go && idx == `FSFB_IDX_FAULT) begin
            force_q <= wbyte[`FSFB_B_FORCE];
        end
    end

    // ----------------------------------------
    // Per-cell flags, cleared with their summary bit
    // ----------------------------------------
    assign ov_clr = {`FSFB_NCELL{flag_clr[`FSFB_B_COV]}};
    assign uv_clr = {`FSFB_NCELL{flag_clr[`FSFB_B_CUV]}};

    fsfb_sticky_bits #(.W(`FSFB_NCELL), .RST(`FSFB_ZERO6)) u_ov_cells (
        .clk(clk),
        .resetn(resetn),
        .set(high_cell_bits),
        .clr(ov_clr),
        .q(ov_cell_q)
    );

    fsfb_sticky_bits #(.W(`FSFB_NCELL), .RST(`FSFB_ZERO6)) u_uv_cells (
        .clk(clk),
        .resetn(resetn),
        .set(low_cell_bits),
        .clr(uv_clr),
        .q(uv_cell_q)
    );

    // ----------------------------------------
    // Parity results
    // ----------------------------------------
    fsfb_parity_bank #(.N(`FSFB_NPROT)) u_parity (
        .clk(clk),
        .resetn(resetn),
        .cfg_bytes(protected_config_group),
        .odd_sense(parity_odd_sense),
        .result_q(par_q)
    );

    // ----------------------------------------
    // Power-on load strobe
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            por_pend_q <= 1'b1;
            cfg_load <= 1'b0;
        end else begin
            por_pend_q <= 1'b0;
            cfg_load <= por_pend_q;
        end
    end

    // ----------------------------------------
    // Fault output
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fault_out <= 1'b0;
        end else begin
            fault_out <= force_q || flag_q[`FSFB_B_COV] || flag_q[`FSFB_B_CUV];
        end
    end

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    assign irq_clr = (wr_go && idx == `FSFB_IDX_IRQ_CLR) ? wbyte[`FSFB_NFLAG-1:0] : `FSFB_ZERO6;

    fsfb_sticky_bits #(.W(`FSFB_NFLAG), .RST(`FSFB_ZERO6)) u_irq_stat (
        .clk(clk),
        .resetn(resetn),
        .set(flag_set),
        .clr(irq_clr),
        .q(irq_stat_q)
    );

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_en_q <= `FSFB_IRQ_EN_RST;
        end else if (wr_go && idx == `FSFB_IDX_IRQ_EN) begin
            irq_en_q <= wbyte[`FSFB_NFLAG-1:0];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_en_q);
        end
    end

    // ----------------------------------------
    // Read back
    // ----------------------------------------
    always_comb begin
        rd_d = '0;
        unique case (idx)
            `FSFB_IDX_FAULT: begin
                rd_d = {2'h0, flag_q};
                rd_d[`FSFB_B_FORCE] = force_q;
            end
            `FSFB_IDX_OVCELL: rd_d = {2'h0, ov_cell_q};
            `FSFB_IDX_UVCELL: rd_d = {2'h0, uv_cell_q};
            `FSFB_IDX_PAR_LO: rd_d = par_q[7:0];
            `FSFB_IDX_PAR_HI: rd_d = par_q[15:8];
            `FSFB_IDX_IRQ_STAT: rd_d = {2'h0, irq_stat_q};
            `FSFB_IDX_IRQ_EN: rd_d = {2'h0, irq_en_q};
            default: rd_d = '0;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_go) begin
            avs_readdata <= {24'h00_0000, rd_d};
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_wait_one_cycle: assert property (@(posedge clk) disable iff (!resetn)
        ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest timing wrong");
    a_consistency_sets: assert property (@(posedge clk) disable iff (!resetn)
        consistency_err |=> flag_q[`FSFB_B_CONS])
        else $error("consistency flag not set");
    a_force_drives_fault: assert property (@(posedge clk) disable iff (!resetn)
        force_q |=> fault_out)
        else $error("force did not assert fault");
    a_por_flag_load: assert property (@(posedge clk) disable iff (!resetn)
        cfg_load |-> flag_q[`FSFB_B_POR] && !$past(cfg_load))
        else $error("power-on flag or load strobe wrong");
    a_crc_sets: assert property (@(posedge clk) disable iff (!resetn)
        crc_err |=> flag_q[`FSFB_B_CRC])
        else $error("check-code flag not set");
    a_uv_summary: assert property (@(posedge clk) disable iff (!resetn)
        (|low_cell_bits) |=> flag_q[`FSFB_B_CUV] && ((uv_cell_q & $past(low_cell_bits)) == $past(low_cell_bits)))
        else $error("undervoltage flags wrong");
    a_ov_summary: assert property (@(posedge clk) disable iff (!resetn)
        (|high_cell_bits) |=> flag_q[`FSFB_B_COV] && ((ov_cell_q & $past(high_cell_bits)) == $past(high_cell_bits)))
        else $error("overvoltage flags wrong");
    a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
        (rd_go && (idx == `FSFB_IDX_FAULT || idx == `FSFB_IDX_OVCELL || idx == `FSFB_IDX_UVCELL))
        |=> avs_readdata[7:6] == 2'h0)
        else $error("reserved bits not zero");
    a_irq_level: assert property (@(posedge clk) disable iff (!resetn)
        ##1 irq == $past(|(irq_stat_q & irq_en_q)))
        else $error("interrupt level wrong");
endmodule

// *** src/fsfb_defs.svh ***
`ifndef FSFB_DEFS_SVH
`define FSFB_DEFS_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define FSFB_IDX_FAULT 6'h21
`define FSFB_IDX_OVCELL 6'h22
`define FSFB_IDX_UVCELL 6'h23
`define FSFB_IDX_PAR_LO 6'h24
`define FSFB_IDX_PAR_HI 6'h25
`define FSFB_IDX_IRQ_STAT 6'h28
`define FSFB_IDX_IRQ_CLR 6'h29
`define FSFB_IDX_IRQ_EN 6'h2a

// ----------------------------------------
// Fault source field positions
// ----------------------------------------
`define FSFB_B_COV 0
`define FSFB_B_CUV 1
`define FSFB_B_CRC 2
`define FSFB_B_POR 3
`define FSFB_B_FORCE 4
`define FSFB_B_CONS 5

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define FSFB_NFLAG 6
`define FSFB_NCELL 6
`define FSFB_NPROT 16
`define FSFB_FLAG_RST 6'h08
`define FSFB_ZERO6 6'h00
`define FSFB_IRQ_EN_RST 6'h00
`define FSFB_FORCE_RST 1'h0

`endif

// *** src/fsfb_pkg.sv ***
package fsfb_pkg;
    typedef logic [7:0] fsfb_byte_t;
    typedef logic [5:0] fsfb_idx_t;
    typedef logic [5:0] fsfb_flags_t;
endpackage

// *** src/fsfb_sticky_bits.sv ***
`timescale 1ns/1ps
module fsfb_sticky_bits #(
    parameter int W = 6,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Set and clear
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    // State
    output logic [W-1:0] q
);
    // ----------------------------------------
    // Sticky bits, set wins over clear
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= RST;
        end else begin
            q <= (q & ~clr) | set;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_set_wins: assert property (@(posedge clk) disable iff (!resetn)
        (set != '0) |=> ((q & $past(set)) == $past(set)))
        else $error("set bit lost");
    a_clear_takes: assert property (@(posedge clk) disable iff (!resetn)
        (clr != '0) |=> ((q & $past(clr) & ~$past(set)) == '0))
        else $error("cleared bit stayed set");
endmodule

// *** src/fsfb_parity_bank.sv ***
`timescale 1ns/1ps
module fsfb_parity_bank #(
    parameter int N = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Protected configuration bytes, register 0 in the low byte
    input wire logic [N*8-1:0] cfg_bytes,
    input wire logic odd_sense,
    // One result bit per register
    output logic [N-1:0] result_q
);
    logic [N-1:0] result_d;

    // ----------------------------------------
    // Per-register parity
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_par
            assign result_d[i] = (^cfg_bytes[i*8 +: 8]) ^ odd_sense;
        end
    endgenerate

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            result_q <= '0;
        end else begin
            result_q <= result_d;
        end
    end

    a_parity_track: assert property (@(posedge clk) disable iff (!resetn)
        $past(resetn) |-> result_q[0] == $past((^cfg_bytes[7:0]) ^ odd_sense))
        else $error("parity result wrong");
endmodule

// *** tb/fsfb_host.sv ***
`timescale 1ns/1ps
module fsfb_host (
    // Clock
    input wire logic clk,
    // Bus master side
    output logic [7:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata,
    output logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest
);
    // ----------------------------------------
    // Host transfer, held until waitrequest low
    // ----------------------------------------
    initial begin
        {address, read, write, writedata, byteenable} = '0;
    end
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic be0,
        output logic [31:0] q);
        @(posedge clk);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= {24'h0, d};
        byteenable <= be0 ? 4'hf : 4'he;
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
endmodule

// *** tb/test_fault_status_flag_bank.sv ***
`timescale 1ns/1ps
module test_fault_status_flag_bank;
    // ----------------------------------------
    // Signals, design and host
    // ----------------------------------------
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] address;
    logic read, write, waitrequest, fault_out, cfg_load, irq;
    logic [31:0] writedata, readdata, q;
    logic [3:0] byteenable;
    logic cons_err = 1'b0, crc_err = 1'b0, odd_sense = 1'b0;
    logic [5:0] hi_bits = 6'h00, lo_bits = 6'h00;
    logic [127:0] cfg = '0;
    int errors = 0, num_checks = 0, cyc = 0, loads = 0;
    int fl, ovc, uvc, st, en, frc, par, m;
    initial forever #2.5 clk = ~clk;
    fsfb_top u_dut (.clk(clk), .resetn(resetn), .avs_address(address), .avs_read(read), .avs_write(write),
        .avs_writedata(writedata), .avs_byteenable(byteenable), .avs_readdata(readdata),
        .avs_waitrequest(waitrequest), .consistency_err(cons_err), .crc_err(crc_err),
        .high_cell_bits(hi_bits), .low_cell_bits(lo_bits), .protected_config_group(cfg),
        .parity_odd_sense(odd_sense), .fault_out(fault_out), .cfg_load(cfg_load), .irq(irq));
    fsfb_host u_host (.clk(clk), .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rd(input logic [7:0] a, input int exp, input string name);
        u_host.xfer(1'b0, a, 8'h00, 1'b1, q);
        chk(name, q, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.xfer(1'b1, a, d, 1'b1, q);
        if (a == 8'h84) begin
            fl &= ~(d & 8'h2f);
            frc = d[4];
            if (d[0]) ovc = 0;
            if (d[1]) uvc = 0;
        end
        if (a == 8'ha4) st &= ~d;
        if (a == 8'ha8) en = d & 8'h3f;
    endtask
    task automatic chk_all();
        rd(8'h84, fl | (frc << 4), "fault_source");
        rd(8'h88, ovc, "ov_cells");
        rd(8'h8c, uvc, "uv_cells");
        rd(8'ha0, st, "irq_status");
        rd(8'ha8, en, "irq_enable");
        chk("fault_out", fault_out, (frc | fl & 3) != 0);
        chk("irq", irq, (st & en) != 0);
    endtask
    task automatic ev(input int kind, input logic [5:0] b);
        @(posedge clk);
        case (kind)
            0: hi_bits <= b;
            1: lo_bits <= b;
            2: crc_err <= 1'b1;
            default: cons_err <= 1'b1;
        endcase
        @(posedge clk);
        {hi_bits, lo_bits, crc_err, cons_err} <= '0;
        repeat (2) @(posedge clk);
        m = (kind == 3) ? 32 : (1 << kind);
        fl |= m;
        st |= m;
        if (kind == 0) ovc |= b;
        if (kind == 1) uvc |= b;
    endtask
    task automatic par_chk();
        @(posedge clk);
        cfg <= {$urandom, $urandom, $urandom, $urandom};
        odd_sense <= 1'($urandom_range(0, 1));
        repeat (2) @(posedge clk);
        par = 0;
        for (int i = 0; i < 16; i++) par |= (^cfg[i*8 +: 8] ^ odd_sense) << i;
        rd(8'h90, par & 255, "parity_low");
        rd(8'h94, par >> 8, "parity_high");
    endtask
    task automatic do_reset();
        resetn <= 1'b0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        {fl, ovc, uvc, st, en, frc} = {32'd8, 160'd0};
    endtask
    task automatic print_verdict();
        if (errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cfg_load === 1'b1) loads++;
        if (cyc == 20000) begin
            errors++;
            print_verdict();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h3ba81f9f));
        do_reset();
        chk_all();
        chk("cfg_load", loads, 1);
        repeat (3) par_chk();
        wr(8'h84, 8'h08);
        wr(8'ha8, 8'h27);
        chk_all();
        for (int k = 0; k < 5; k++) begin
            ev(k % 4, 6'($urandom_range(1, 63)));
            chk_all();
        end
        u_host.xfer(1'b1, 8'h84, 8'hff, 1'b0, q);
        wr(8'h84, 8'hd0);
        chk_all();
        wr(8'h84, 8'h01);
        wr(8'h88, 8'h3f);
        chk_all();
        wr(8'ha8, 8'h00);
        chk_all();
        wr(8'ha4, 8'hff);
        wr(8'h84, 8'h2f);
        chk_all();
        wr(8'h84, 8'h00);
        chk_all();
        rd(8'h00, 0, "unmapped");
        rd(8'ha4, 0, "irq_clear");
        ev(2, 6'h00);
        ev(3, 6'h00);
        do_reset();
        chk_all();
        chk("cfg_load", loads, 2);
        print_verdict();
    end
endmodule
